// ===== src/tscw_pkg.sv
// Package of constants and types for the terminal status control word block.
package tscw_pkg;
    // Width of the control word written by the host controller.
    localparam int unsigned WORD_W = 16;
    // Bit positions inside the control word.
    localparam int unsigned BIT_DISPLAY  = 15;
    localparam int unsigned BIT_PRIORITY = 14;
    localparam int unsigned BIT_BUZ_CONT = 13;
    localparam int unsigned BIT_BUZ_INT  = 12;
    localparam int unsigned BIT_FLASH    = 8;
    // Bits that carry a function; the others are ignored.
    localparam logic [15:0] USED_MASK = 16'hF100;
    // Baseline value held before the first word is seen.
    localparam logic [15:0] WORD_RST = 16'h0000;
    // Buzzer on and off period, and the clock rate.
    localparam int unsigned HALF_PERIOD_MS = 500;
    localparam int unsigned CLK_KHZ        = 125000;
    localparam int unsigned HALF_CYCLES    = HALF_PERIOD_MS * CLK_KHZ;
    localparam int unsigned TMR_W          = 26;

    // Buzzer pattern selected by the word.
    typedef enum logic [1:0] {
        TSCW_BZ_OFF  = 2'b00,
        TSCW_BZ_CONT = 2'b01,
        TSCW_BZ_INT  = 2'b11
    } tscw_buz_type;

    // Keeps only the bits that have a function.
    function automatic logic [15:0] tscw_used(input logic [15:0] w);
        tscw_used = w & USED_MASK;
    endfunction : tscw_used
endpackage : tscw_pkg

// ===== src/tscw_change_det.sv
// Detector that reacts only to changes of the control word after start-up.
`timescale 1ns/1ps
`default_nettype none
module tscw_change_det (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Word as read from the controller memory.
    input  wire logic        word_valid,
    input  wire logic [15:0] word,
    // Change pulse and the new meaningful bits.
    output logic             change,
    output logic [15:0]      new_word
);
    logic        armed;
    logic        next_armed;
    logic        next_change;
    logic [15:0] next_new_word;
    logic [15:0] used_now;

    // First read is baseline only; later reads act on a difference.
    always_comb begin
        used_now      = tscw_pkg::tscw_used(word);
        next_armed    = armed;
        next_change   = 1'b0;
        next_new_word = new_word;
        if (word_valid) begin
            next_new_word = used_now;
            if (!armed) begin
                next_armed = 1'b1;
            end else if (used_now != new_word) begin
                next_change = 1'b1;
            end
        end
    end

    // State registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            armed    <= 1'b0;
            change   <= 1'b0;
            new_word <= tscw_pkg::WORD_RST;
        end else begin
            armed    <= next_armed;
            change   <= next_change;
            new_word <= next_new_word;
        end
    end

    // The first word after reset never triggers control.
    AST_NO_START_ACT: assert property (@(posedge ref_clk) disable iff (rst)
        (word_valid && !armed) |=> !change)
        else $error("Start-up word caused an action.");

    // A differing word produces a change pulse.
    AST_CHANGE_ACT: assert property (@(posedge ref_clk) disable iff (rst)
        (word_valid && armed && (tscw_pkg::tscw_used(word) != new_word)) |=> change)
        else $error("Word change was not acted on.");

    // Unused bits alone never cause a change.
    AST_UNUSED_IGN: assert property (@(posedge ref_clk) disable iff (rst)
        (word_valid && (tscw_pkg::tscw_used(word) == new_word)) |=> !change)
        else $error("Unused bits caused a change.");
endmodule : tscw_change_det
`default_nettype wire

// ===== src/tscw_half_timer.sv
// Half-period timebase that gives the on and off phases of the cadence.
`timescale 1ns/1ps
`default_nettype none
module tscw_half_timer #(
    parameter int unsigned HALF_CYCLES = tscw_pkg::HALF_CYCLES
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst,
    // Control of the cadence.
    input  wire logic run,
    input  wire logic restart,
    // High during the sounding half.
    output logic      phase
);
    localparam int unsigned                LAST_I = HALF_CYCLES - 1;
    localparam logic [tscw_pkg::TMR_W-1:0] LAST   = LAST_I[tscw_pkg::TMR_W-1:0];

    logic [tscw_pkg::TMR_W-1:0] cnt;
    logic [tscw_pkg::TMR_W-1:0] next_cnt;
    logic                       next_phase;

    // Count a half period, then swap phase; idle holds the sounding phase.
    always_comb begin
        next_cnt   = cnt + 1'b1;
        next_phase = phase;
        if (!run || restart) begin
            next_cnt   = '0;
            next_phase = 1'b1;
        end else if (cnt == LAST) begin
            next_cnt   = '0;
            next_phase = !phase;
        end
    end

    // State registers.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt   <= '0;
            phase <= 1'b1;
        end else begin
            cnt   <= next_cnt;
            phase <= next_phase;
        end
    end

    // Phase swaps exactly at the end of each half period.
    AST_HALF_SWAP: assert property (@(posedge ref_clk) disable iff (rst)
        (run && !restart && cnt == LAST) |=> (phase != $past(phase)))
        else $error("Cadence phase did not swap.");

    // Phase holds inside a half period.
    AST_HALF_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        (run && !restart && cnt != LAST) |=> (phase == $past(phase)))
        else $error("Cadence phase moved early.");
endmodule : tscw_half_timer
`default_nettype wire

// ===== src/tscw_ctrl.sv
// Terminal status control word decoder driving display, priority and buzzer.
`timescale 1ns/1ps
`default_nettype none
module tscw_ctrl #(
    parameter int unsigned HALF_CYCLES = tscw_pkg::HALF_CYCLES
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Control word as read from controller memory.
    input  wire logic        word_valid,
    input  wire logic [15:0] terminal_control_word,
    // Terminal settings.
    input  wire logic        link_one_to_many,
    input  wire logic        buzzer_enable,
    // Touch panel events.
    input  wire logic        touch_press,
    input  wire logic        touch_buzz_stop,
    // Another terminal took priority later.
    input  wire logic        priority_taken,
    // Terminal outputs.
    output logic             display_on,
    output logic             backlight_on,
    output logic             priority_req,
    output logic             buzzer_out
);
    logic                   change;
    logic [15:0]            w;
    logic                   phase;
    tscw_pkg::tscw_buz_type buz_mode;
    tscw_pkg::tscw_buz_type next_buz_mode;
    logic                   flash_en;
    logic                   next_flash_en;
    logic                   next_display_on;
    logic                   next_backlight_on;
    logic                   next_priority_req;
    logic                   next_buzzer_out;
    logic                   timer_run;

    // Change detection; the word is only ever read here.
    tscw_change_det u_det (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .word_valid (word_valid),
        .word       (terminal_control_word),
        .change     (change),
        .new_word   (w)
    );

    // Cadence runs while intermittent buzzer or flashing is active.
    assign timer_run = (buz_mode == tscw_pkg::TSCW_BZ_INT) || (flash_en && display_on);

    // Shared half-second cadence for buzzer and backlight flashing.
    tscw_half_timer #(
        .HALF_CYCLES (HALF_CYCLES)
    ) u_tmr (
        .ref_clk (ref_clk),
        .rst     (rst),
        .run     (timer_run),
        .restart (change),
        .phase   (phase)
    );

    // Screen display state.
    always_comb begin
        next_display_on = display_on;
        if (change) begin
            next_display_on = w[tscw_pkg::BIT_DISPLAY];
        end else if (touch_press && !display_on) begin
            next_display_on = 1'b1;
        end
    end

    // Flash enable follows the word; it only matters while displayed.
    always_comb begin
        next_flash_en = flash_en;
        if (change) begin
            next_flash_en = w[tscw_pkg::BIT_FLASH];
        end
    end

    // Backlight: off when blanked, toggled when flashing, else steady.
    always_comb begin
        if (!display_on) begin
            next_backlight_on = 1'b0;
        end else if (flash_en) begin
            next_backlight_on = phase;
        end else begin
            next_backlight_on = 1'b1;
        end
    end

    // Priority request; a later registration elsewhere drops ours.
    always_comb begin
        next_priority_req = priority_req;
        if (priority_taken) begin
            next_priority_req = 1'b0;
        end
        if (change) begin
            next_priority_req = w[tscw_pkg::BIT_PRIORITY];
        end
        if (!link_one_to_many) begin
            next_priority_req = 1'b0;
        end
    end

    // Buzzer pattern; a new word wins over a stop press in the same cycle.
    always_comb begin
        next_buz_mode = buz_mode;
        if (change) begin
            if (w[tscw_pkg::BIT_BUZ_CONT]) begin
                next_buz_mode = tscw_pkg::TSCW_BZ_CONT;
            end else if (w[tscw_pkg::BIT_BUZ_INT]) begin
                next_buz_mode = tscw_pkg::TSCW_BZ_INT;
            end else begin
                next_buz_mode = tscw_pkg::TSCW_BZ_OFF;
            end
        end else if (touch_buzz_stop) begin
            next_buz_mode = tscw_pkg::TSCW_BZ_OFF;
        end
    end

    // Buzzer drive gated by the stored enable setting.
    always_comb begin
        next_buzzer_out = 1'b0;
        if (buzzer_enable) begin
            unique case (buz_mode)
                tscw_pkg::TSCW_BZ_OFF:  next_buzzer_out = 1'b0;
                tscw_pkg::TSCW_BZ_CONT: next_buzzer_out = 1'b1;
                tscw_pkg::TSCW_BZ_INT:  next_buzzer_out = phase;
                default:                next_buzzer_out = 1'b0;
            endcase
        end
    end

    // State registers; all outputs come from here.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            display_on   <= 1'b1;
            backlight_on <= 1'b0;
            priority_req <= 1'b0;
            buzzer_out   <= 1'b0;
            buz_mode     <= tscw_pkg::TSCW_BZ_OFF;
            flash_en     <= 1'b0;
        end else begin
            display_on   <= next_display_on;
            backlight_on <= next_backlight_on;
            priority_req <= next_priority_req;
            buzzer_out   <= next_buzzer_out;
            buz_mode     <= next_buz_mode;
            flash_en     <= next_flash_en;
        end
    end

    // Blanking word turns display off, then backlight a cycle later.
    AST_BLANK: assert property (@(posedge ref_clk) disable iff (rst)
        (change && !w[tscw_pkg::BIT_DISPLAY]) |=> !display_on ##1 !backlight_on)
        else $error("Blanking did not clear display and backlight.");

    // A touch while blanked restores the display and backlight.
    AST_TOUCH_WAKE: assert property (@(posedge ref_clk) disable iff (rst)
        (touch_press && !display_on && !change) |=> display_on ##1 (backlight_on || flash_en))
        else $error("Touch did not restore the screen.");

    // Priority bit set in one-to-many mode raises the request.
    AST_PRIO_SET: assert property (@(posedge ref_clk) disable iff (rst)
        (change && w[tscw_pkg::BIT_PRIORITY] && link_one_to_many) |=> priority_req)
        else $error("Priority was not registered.");

    // Priority bit cleared cancels the request.
    AST_PRIO_CLR: assert property (@(posedge ref_clk) disable iff (rst)
        (change && !w[tscw_pkg::BIT_PRIORITY]) |=> !priority_req)
        else $error("Priority was not cancelled.");

    // A later registration elsewhere takes priority away.
    AST_PRIO_LOST: assert property (@(posedge ref_clk) disable iff (rst)
        (priority_taken && !change) |=> !priority_req)
        else $error("Priority kept after a later registration.");

    // Outside one-to-many mode priority never shows.
    AST_PRIO_MODE: assert property (@(posedge ref_clk) disable iff (rst)
        !link_one_to_many |=> !priority_req)
        else $error("Priority active outside one-to-many mode.");

    // Continuous buzzer sounds without gaps for as long as it is selected and the enable setting is on.
    AST_BUZ_STEADY: assert property (@(posedge ref_clk) disable iff (rst)
        (buz_mode == tscw_pkg::TSCW_BZ_CONT && buzzer_enable) |=> buzzer_out)
        else $error("Continuous buzzer had a gap.");

    // Both buzzer bits select the continuous pattern.
    AST_BUZ_PRIO: assert property (@(posedge ref_clk) disable iff (rst)
        (change && w[tscw_pkg::BIT_BUZ_CONT] && w[tscw_pkg::BIT_BUZ_INT])
        |=> (buz_mode == tscw_pkg::TSCW_BZ_CONT))
        else $error("Intermittent pattern won over continuous.");

    // With the enable setting off the buzzer stays silent.
    AST_BUZ_EN: assert property (@(posedge ref_clk) disable iff (rst)
        !buzzer_enable |=> !buzzer_out)
        else $error("Buzzer sounded while disabled.");

    // A buzzer-stop press silences the buzzer within two cycles.
    AST_BUZ_STOP: assert property (@(posedge ref_clk) disable iff (rst)
        (touch_buzz_stop && !change) |=> (buz_mode == tscw_pkg::TSCW_BZ_OFF) ##1 !buzzer_out)
        else $error("Buzzer-stop press did not silence the buzzer.");

    // Without flashing, a shown screen has a steady backlight.
    AST_STEADY_BL: assert property (@(posedge ref_clk) disable iff (rst)
        (display_on && !flash_en) |=> backlight_on)
        else $error("Backlight not steady in normal display.");

    // A blanked screen keeps its backlight dark.
    AST_DARK_BL: assert property (@(posedge ref_clk) disable iff (rst)
        !display_on |=> !backlight_on)
        else $error("Backlight lit while the screen is blanked.");

    // A word with the display bit set shows the screen.
    AST_WORD_SHOW: assert property (@(posedge ref_clk) disable iff (rst)
        (change && w[tscw_pkg::BIT_DISPLAY]) |=> display_on)
        else $error("Display bit did not show the screen.");

    // A touch wake without flashing relights the backlight steadily.
    AST_TOUCH_BL: assert property (@(posedge ref_clk) disable iff (rst)
        (touch_press && !display_on && !change && !flash_en) |=> ##1 backlight_on)
        else $error("Touch wake left the backlight dark.");

    // Priority moves only on a word change, a later registration or the link mode.
    AST_PRIO_STILL: assert property (@(posedge ref_clk) disable iff (rst)
        (!change && !priority_taken && link_one_to_many) |=> (priority_req == $past(priority_req)))
        else $error("Priority request moved on its own.");

    // Only the intermittent bit selects the intermittent pattern.
    AST_BUZ_INT_SEL: assert property (@(posedge ref_clk) disable iff (rst)
        (change && !w[tscw_pkg::BIT_BUZ_CONT] && w[tscw_pkg::BIT_BUZ_INT])
        |=> (buz_mode == tscw_pkg::TSCW_BZ_INT))
        else $error("Intermittent bit did not select its pattern.");

    // Only the continuous bit selects the continuous pattern.
    AST_BUZ_CONT_SEL: assert property (@(posedge ref_clk) disable iff (rst)
        (change && w[tscw_pkg::BIT_BUZ_CONT] && !w[tscw_pkg::BIT_BUZ_INT])
        |=> (buz_mode == tscw_pkg::TSCW_BZ_CONT))
        else $error("Continuous bit did not select its pattern.");

    // Both buzzer bits clear silence the buzzer pattern.
    AST_BUZ_OFF_SEL: assert property (@(posedge ref_clk) disable iff (rst)
        (change && !w[tscw_pkg::BIT_BUZ_CONT] && !w[tscw_pkg::BIT_BUZ_INT])
        |=> (buz_mode == tscw_pkg::TSCW_BZ_OFF))
        else $error("Cleared buzzer bits left a pattern selected.");

    // No pattern selected means no sound.
    AST_BUZ_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
        (buz_mode == tscw_pkg::TSCW_BZ_OFF) |=> !buzzer_out)
        else $error("Buzzer sounded with no pattern selected.");

    // The intermittent buzzer follows the cadence phase.
    AST_BUZ_CADENCE: assert property (@(posedge ref_clk) disable iff (rst)
        (buz_mode == tscw_pkg::TSCW_BZ_INT && buzzer_enable) |=> (buzzer_out == $past(phase)))
        else $error("Intermittent buzzer left the cadence.");

    // A selected pattern stays silent while the enable setting is off.
    AST_BUZ_MUTED: assert property (@(posedge ref_clk) disable iff (rst)
        (buz_mode != tscw_pkg::TSCW_BZ_OFF && !buzzer_enable) |=> !buzzer_out)
        else $error("Selected pattern sounded while disabled.");

    // Flashing toggles the backlight with the cadence phase.
    AST_FLASH_PHASE: assert property (@(posedge ref_clk) disable iff (rst)
        (display_on && flash_en) |=> (backlight_on == $past(phase)))
        else $error("Flashing backlight left the cadence.");

    // A word with the flash bit set enables flashing.
    AST_FLASH_SET: assert property (@(posedge ref_clk) disable iff (rst)
        (change && w[tscw_pkg::BIT_FLASH]) |=> flash_en)
        else $error("Flash bit did not enable flashing.");

    // A word with the flash bit clear ends flashing.
    AST_FLASH_CLR: assert property (@(posedge ref_clk) disable iff (rst)
        (change && !w[tscw_pkg::BIT_FLASH]) |=> !flash_en)
        else $error("Cleared flash bit left flashing on.");

    // A blanking word with the flash bit set still darkens the backlight.
    AST_FLASH_BLANK: assert property (@(posedge ref_clk) disable iff (rst)
        (change && !w[tscw_pkg::BIT_DISPLAY] && w[tscw_pkg::BIT_FLASH]) |=> ##1 !backlight_on)
        else $error("Flash bit lit a blanked screen.");

    // The display moves only on a word change or a touch.
    AST_DISP_STILL: assert property (@(posedge ref_clk) disable iff (rst)
        (!change && !touch_press) |=> (display_on == $past(display_on)))
        else $error("Display state moved on its own.");

    // The buzzer pattern moves only on a word change or a stop press.
    AST_BUZ_STILL: assert property (@(posedge ref_clk) disable iff (rst)
        (!change && !touch_buzz_stop) |=> (buz_mode == $past(buz_mode)))
        else $error("Buzzer pattern moved on its own.");
endmodule : tscw_ctrl
`default_nettype wire

// ===== test/tscw_host_model.sv
// Model of the host controller that holds the control word and lets the terminal poll it.
`timescale 1ns/1ps
`default_nettype none
module tscw_host_model #(
    parameter int unsigned POLL = 4
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Word held in controller memory.
    input  wire logic [15:0] mem_word,
    // Read presented to the terminal.
    output logic             word_valid,
    output logic [15:0]      terminal_control_word
);
    int unsigned cnt;

    // Presents a read every POLL cycles; between reads the data lines show the inverse of memory.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt                   <= 0;
            word_valid            <= 1'b0;
            terminal_control_word <= 16'h0000;
        end else begin
            cnt                   <= (cnt == POLL - 1) ? 0 : cnt + 1;
            word_valid            <= (cnt == POLL - 1);
            terminal_control_word <= (cnt == POLL - 1) ? mem_word : ~mem_word;
        end
    end
endmodule : tscw_host_model
`default_nettype wire

// ===== test/terminal_status_control_word_tb.sv
// Self-checking testbench for the terminal status control word decoder.
`timescale 1ns/1ps
`default_nettype none
module terminal_status_control_word_tb;
    localparam int unsigned HALF = 8;
    localparam int DS = 0;
    localparam int BL = 1;
    localparam int PR = 2;
    localparam int BZ = 3;
    logic        ref_clk          = 1'b0;
    logic        rst              = 1'b1;
    logic [15:0] mem_word         = 16'h3000;
    logic        link_one_to_many = 1'b1;
    logic        buzzer_enable    = 1'b1;
    logic        touch_press      = 1'b0;
    logic        touch_buzz_stop  = 1'b0;
    logic        priority_taken   = 1'b0;
    logic        word_valid;
    logic [15:0] terminal_control_word;
    logic        display_on;
    logic        backlight_on;
    logic        priority_req;
    logic        buzzer_out;
    int          err_count        = 0;
    int          checks_done      = 0;
    int          n;
    string       nm [4]           = '{"display_on", "backlight_on", "priority_req", "buzzer_out"};

    tscw_host_model tscw_host_model_i (
        .ref_clk(ref_clk), .rst(rst), .mem_word(mem_word),
        .word_valid(word_valid), .terminal_control_word(terminal_control_word));

    tscw_ctrl #(.HALF_CYCLES(HALF)) tscw_ctrl_i (
        .ref_clk(ref_clk), .rst(rst), .word_valid(word_valid),
        .terminal_control_word(terminal_control_word), .link_one_to_many(link_one_to_many),
        .buzzer_enable(buzzer_enable), .touch_press(touch_press), .touch_buzz_stop(touch_buzz_stop),
        .priority_taken(priority_taken), .display_on(display_on), .backlight_on(backlight_on),
        .priority_req(priority_req), .buzzer_out(buzzer_out));

    // Clock at 125 MHz.
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    // Picks one terminal output by index.
    function automatic logic sig(input int s);
        case (s)
            DS: sig = display_on;
            BL: sig = backlight_on;
            PR: sig = priority_req;
            default: sig = buzzer_out;
        endcase
    endfunction : sig

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("err_count=%0d checks_done=%0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // Compares one value and counts it.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
            err_count++;
        end
    endtask : chk

    // Writes a new word into controller memory.
    task automatic set_word(input logic [15:0] w);
        @(posedge ref_clk);
        mem_word <= w;
    endtask : set_word

    // Waits a bounded time for an output to reach a level; running out ends the run.
    task automatic wait_for(input int s, input logic v, input int bound);
        int i;
        i = 0;
        while (sig(s) !== v && i < bound) begin
            @(negedge ref_clk);
            i++;
        end
        chk(nm[s], {15'h0000, v}, {15'h0000, sig(s)});
        if (sig(s) !== v) close_out();
    endtask : wait_for

    // Checks that an output keeps one level for a number of cycles.
    task automatic hold(input int s, input logic v, input int cyc);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < cyc; i++) begin
            @(negedge ref_clk);
            if (sig(s) !== v) bad = 1'b1;
        end
        chk(nm[s], {15'h0000, v}, {15'h0000, v ^ bad});
    endtask : hold

    // Counts the cycles for which an output keeps its present level.
    task automatic run_len(input int s, input logic v, output int cnt);
        cnt = 0;
        while (sig(s) === v && cnt < 100) begin
            @(negedge ref_clk);
            cnt++;
        end
    endtask : run_len

    // Raises one touch input or the priority-taken input for a single cycle.
    task automatic pulse(input int which);
        @(posedge ref_clk);
        if (which == 0) touch_press <= 1'b1;
        else if (which == 1) touch_buzz_stop <= 1'b1;
        else priority_taken <= 1'b1;
        @(posedge ref_clk);
        touch_press     <= 1'b0;
        touch_buzz_stop <= 1'b0;
        priority_taken  <= 1'b0;
    endtask : pulse

    // Start-up contents, unused bits, and blanking with both ways back.
    task automatic t_start_blank();
        hold(BZ, 1'b0, 30);
        wait_for(BL, 1'b1, 5);
        set_word(16'h30FF);
        hold(BZ, 1'b0, 20);
        set_word(16'h0000);
        wait_for(DS, 1'b0, 20);
        wait_for(BL, 1'b0, 3);
        pulse(0);
        wait_for(DS, 1'b1, 4);
        wait_for(BL, 1'b1, 4);
        set_word(16'h8000);
        hold(DS, 1'b1, 20);
        set_word(16'h0000);
        wait_for(DS, 1'b0, 20);
        set_word(16'h8000);
        wait_for(DS, 1'b1, 20);
        wait_for(BL, 1'b1, 3);
    endtask : t_start_blank

    // Intermittent cadence, enable setting, continuous priority, stop switch and repeat.
    task automatic t_buzzer();
        set_word(16'h9000);
        wait_for(BZ, 1'b1, 20);
        run_len(BZ, 1'b1, n);
        run_len(BZ, 1'b0, n);
        chk("buzzer off run", 16'(HALF), 16'(n));
        run_len(BZ, 1'b1, n);
        chk("buzzer on run", 16'(HALF), 16'(n));
        @(posedge ref_clk);
        buzzer_enable <= 1'b0;
        set_word(16'hA000);
        hold(BZ, 1'b0, 30);
        set_word(16'h8000);
        hold(BZ, 1'b0, 20);
        @(posedge ref_clk);
        buzzer_enable <= 1'b1;
        set_word(16'hA000);
        wait_for(BZ, 1'b1, 20);
        hold(BZ, 1'b1, 40);
        set_word(16'hB000);
        hold(BZ, 1'b1, 40);
        pulse(1);
        wait_for(BZ, 1'b0, 4);
        hold(BZ, 1'b0, 20);
        set_word(16'h8000);
        hold(BZ, 1'b0, 20);
        set_word(16'hB000);
        wait_for(BZ, 1'b1, 20);
        set_word(16'h8000);
        wait_for(BZ, 1'b0, 20);
    endtask : t_buzzer

    // Priority registration, later registration elsewhere, cancel and link mode.
    task automatic t_priority();
        set_word(16'hC000);
        wait_for(PR, 1'b1, 20);
        pulse(2);
        wait_for(PR, 1'b0, 3);
        set_word(16'h8000);
        hold(PR, 1'b0, 20);
        set_word(16'hC000);
        wait_for(PR, 1'b1, 20);
        set_word(16'h8000);
        wait_for(PR, 1'b0, 20);
        @(posedge ref_clk);
        link_one_to_many <= 1'b0;
        set_word(16'hC000);
        hold(PR, 1'b0, 30);
    endtask : t_priority

    // Backlight flashing, return to steady, and flash ignored while blanked.
    task automatic t_flash();
        set_word(16'h8100);
        wait_for(BL, 1'b0, 30);
        run_len(BL, 1'b0, n);
        chk("backlight off run", 16'(HALF), 16'(n));
        run_len(BL, 1'b1, n);
        chk("backlight on run", 16'(HALF), 16'(n));
        set_word(16'h8000);
        wait_for(BL, 1'b1, 30);
        hold(BL, 1'b1, 40);
        set_word(16'h0100);
        wait_for(DS, 1'b0, 20);
        hold(BL, 1'b0, 40);
    endtask : t_flash

    // Main sequence: reset, then every scenario in turn.
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        t_start_blank();
        t_buzzer();
        t_priority();
        t_flash();
        close_out();
    end
endmodule : terminal_status_control_word_tb
`default_nettype wire
